// File: pkt_cnt_pkg.sv
/*
 * shared constants and carriers for the packet-end and rate-compensation counter bank.
 * assumes one core clock domain and a register read port from the management interface logic.
 */
package pkt_cnt_pkg;

	localparam int          CNT_W        = 16;
	localparam int          ADDR_W       = 16;
	localparam int          DEVAD_W      = 5;
	localparam int          LANES        = 4;
	localparam int          LANE_W       = 9;
	localparam int          COL_W        = LANES * LANE_W;
	localparam int          NUM_CNT      = 5;

	// management device holding the counters
	localparam logic [4:0]  CNT_DEVAD    = 5'h01;

	// register addresses
	localparam logic [15:0] LN2_ERR_ADDR = 16'h8012;
	localparam logic [15:0] LN3_ERR_ADDR = 16'h8013;
	localparam logic [15:0] TX_DROP_ADDR = 16'h8014;
	localparam logic [15:0] TX_INS_ADDR  = 16'h8015;
	localparam logic [15:0] RX_DROP_ADDR = 16'h8016;

	localparam logic [15:0] CNT_RESET    = 16'hFFFD;
	localparam logic [15:0] CNT_CLEARED  = 16'h0000;
	localparam logic [15:0] RD_UNMAPPED  = 16'h0000;

	// lane character: bit 8 is the control flag
	localparam int          CTL_BIT      = 8;
	localparam logic [7:0]  CHR_TERM     = 8'hFD;
	localparam logic [7:0]  CHR_IDLE     = 8'h07;
	localparam logic [7:0]  CHR_ALIGN    = 8'h9C;

	// counter indices
	localparam int          IX_LN2       = 0;
	localparam int          IX_LN3       = 1;
	localparam int          IX_TXD       = 2;
	localparam int          IX_TXI       = 3;
	localparam int          IX_RXD       = 4;

	typedef struct packed {
		logic              valid;
		logic [COL_W-1:0]  col;
	} column_t;

	typedef struct packed {
		logic              tx_drop;
		logic              tx_insert;
		logic              rx_drop;
	} rate_events_t;

	typedef struct packed {
		logic              rd;
		logic [DEVAD_W-1:0] devad;
		logic [ADDR_W-1:0] addr;
	} reg_read_t;

endpackage

// File: clear_read_counter.sv
/*
 * one saturating-free 16-bit event counter that clears when read.
 * assumes the caller gives a one-cycle read pulse and a one-cycle event pulse.
 */
module clear_read_counter
	import pkt_cnt_pkg::*;
#(
	parameter int              WIDTH = CNT_W,
	parameter logic [WIDTH-1:0] RST_VAL = WIDTH'(CNT_RESET)
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// control
	input  wire logic             event_in,
	input  wire logic             clear_rd,
	// value
	output logic [WIDTH-1:0]      count
);

	if (WIDTH < 1) begin : g_bad_width
		$error("counter width must be positive");
	end

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (clear_rd) begin
			count_nxt = event_in ? WIDTH'(1) : WIDTH'(0);
		end else if (event_in) begin
			count_nxt = count_r + WIDTH'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_r <= RST_VAL;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count = count_r;

endmodule // clear_read_counter

// File: pkt_cnt_bank.sv
/*
 * packet-end error and rate-compensation statistics counters with clear-on-read access.
 * assumes received columns and rate events are synchronous to clk and reads are one-cycle pulses.
 */
module pkt_cnt_bank
	import pkt_cnt_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// received column stream
	input  column_t           rx_col,
	// rate compensation events
	input  rate_events_t      rate_ev,
	// register read port
	input  reg_read_t         rd_req,
	output logic              rd_valid,
	output logic [CNT_W-1:0]  rd_data
);

	logic              term_pend_r;
	logic              term_pend_nxt;
	logic              term_bad_r;
	logic              term_bad_nxt;
	logic              term_ln3_r;
	logic              term_ln3_nxt;
	logic              rd_valid_r;
	logic              rd_valid_nxt;
	logic [CNT_W-1:0]  rd_data_r;
	logic [CNT_W-1:0]  rd_data_nxt;
	logic [NUM_CNT-1:0] ev;
	logic [NUM_CNT-1:0] clr;
	logic [CNT_W-1:0]  cnt [NUM_CNT];
	logic [LANE_W-1:0] ln [LANES];
	logic              col_idle;
	logic              col_align;
	logic              t2;
	logic              t3;
	logic              follow_bad;
	logic              hit;
	int                sel;

	localparam logic [LANE_W-1:0] K_CHR = {1'b1, CHR_IDLE};
	localparam logic [LANE_W-1:0] A_CHR = {1'b1, CHR_ALIGN};
	localparam logic [LANE_W-1:0] T_CHR = {1'b1, CHR_TERM};

	// lane split and column classes
	always_comb begin
		col_idle  = 1'b1;
		col_align = 1'b1;
		for (int i = 0; i < LANES; i++) begin
			ln[i]     = rx_col.col[i*LANE_W +: LANE_W];
			col_idle  = col_idle && (ln[i] == K_CHR);
			col_align = col_align && (ln[i] == A_CHR);
		end
		t2         = rx_col.valid && (ln[2] == T_CHR);
		t3         = rx_col.valid && (ln[3] == T_CHR);
		follow_bad = rx_col.valid && !(col_idle || col_align);
	end

	// remember a terminate column until its follower arrives
	always_comb begin
		term_pend_nxt = term_pend_r;
		term_bad_nxt  = term_bad_r;
		term_ln3_nxt  = term_ln3_r;
		ev            = '0;
		if (rx_col.valid) begin
			if (term_pend_r) begin
				if (term_ln3_r) begin
					ev[IX_LN3] = follow_bad;
				end else begin
					ev[IX_LN2] = term_bad_r || follow_bad;
				end
			end
			term_pend_nxt = t2 || t3;
			term_ln3_nxt  = t3;
			term_bad_nxt  = t2 && (ln[3] != K_CHR);
		end
		ev[IX_TXD] = rate_ev.tx_drop;
		ev[IX_TXI] = rate_ev.tx_insert;
		ev[IX_RXD] = rate_ev.rx_drop;
	end

	// read decode, device 1 only
	always_comb begin
		clr          = '0;
		hit          = 1'b0;
		sel          = 0;
		rd_valid_nxt = rd_req.rd;
		rd_data_nxt  = rd_req.rd ? RD_UNMAPPED : rd_data_r;
		if (rd_req.rd && rd_req.devad == CNT_DEVAD) begin
			unique case (rd_req.addr)
				LN2_ERR_ADDR: begin hit = 1'b1; sel = IX_LN2; end
				LN3_ERR_ADDR: begin hit = 1'b1; sel = IX_LN3; end
				TX_DROP_ADDR: begin hit = 1'b1; sel = IX_TXD; end
				TX_INS_ADDR:  begin hit = 1'b1; sel = IX_TXI; end
				RX_DROP_ADDR: begin hit = 1'b1; sel = IX_RXD; end
				default:      begin hit = 1'b0; sel = 0; end
			endcase
		end
		if (hit) begin
			clr[sel]    = 1'b1;
			rd_data_nxt = cnt[sel];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			term_pend_r <= 1'b0;
			term_bad_r  <= 1'b0;
			term_ln3_r  <= 1'b0;
			rd_valid_r  <= 1'b0;
			rd_data_r   <= CNT_CLEARED;
		end else begin
			term_pend_r <= term_pend_nxt;
			term_bad_r  <= term_bad_nxt;
			term_ln3_r  <= term_ln3_nxt;
			rd_valid_r  <= rd_valid_nxt;
			rd_data_r   <= rd_data_nxt;
		end
	end

	// one clear-on-read counter per statistic
	generate
		for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
			clear_read_counter #(
				.WIDTH   (CNT_W),
				.RST_VAL (CNT_RESET)
			) u_cnt (
				.clk      (clk),
				.resetn   (resetn),
				.event_in (ev[g]),
				.clear_rd (clr[g]),
				.count    (cnt[g])
			);
		end
	endgenerate

	assign rd_valid = rd_valid_r;
	assign rd_data  = rd_data_r;

	// checks
	property p_ln3_err;
		@(posedge clk) disable iff (!resetn)
		(rx_col.valid && t3 && !term_pend_r) ##1 (rx_col.valid && follow_bad && !clr[IX_LN3])
			|=> cnt[IX_LN3] == $past(cnt[IX_LN3]) + CNT_W'(1);
	endproperty
	a_ln3_err: assert property (p_ln3_err) else $error("lane 3 error not counted");

	property p_ln3_clean;
		@(posedge clk) disable iff (!resetn)
		(rx_col.valid && t3 && !term_pend_r) ##1 (rx_col.valid && col_align && !clr[IX_LN3])
			|=> $stable(cnt[IX_LN3]);
	endproperty
	a_ln3_clean: assert property (p_ln3_clean) else $error("clean lane 3 end counted");

	property p_ln2_same_col;
		@(posedge clk) disable iff (!resetn)
		(t2 && ln[3] != K_CHR && !term_pend_r) ##1 (rx_col.valid && !clr[IX_LN2])
			|=> cnt[IX_LN2] == $past(cnt[IX_LN2]) + CNT_W'(1);
	endproperty
	a_ln2_same_col: assert property (p_ln2_same_col) else $error("lane 2 same-column fault missed");

	property p_ln2_next_col;
		@(posedge clk) disable iff (!resetn)
		(t2 && !term_pend_r) ##1 (rx_col.valid && follow_bad && !clr[IX_LN2])
			|=> cnt[IX_LN2] == $past(cnt[IX_LN2]) + CNT_W'(1);
	endproperty
	a_ln2_next_col: assert property (p_ln2_next_col) else $error("lane 2 next-column fault missed");

	property p_ln2_clean;
		@(posedge clk) disable iff (!resetn)
		(t2 && ln[3] == K_CHR && !term_pend_r) ##1 (rx_col.valid && col_idle && !clr[IX_LN2])
			|=> $stable(cnt[IX_LN2]);
	endproperty
	a_ln2_clean: assert property (p_ln2_clean) else $error("clean lane 2 end counted");

	property p_read_clear;
		@(posedge clk) disable iff (!resetn)
		(hit && sel == IX_TXD && !rate_ev.tx_drop) |=> (cnt[IX_TXD] == CNT_CLEARED && rd_valid);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear counter");

	property p_read_value;
		@(posedge clk) disable iff (!resetn)
		hit |=> rd_data == $past(cnt[sel]);
	endproperty
	a_read_value: assert property (p_read_value) else $error("read returned wrong value");

	property p_tx_ins;
		@(posedge clk) disable iff (!resetn)
		(rate_ev.tx_insert && !clr[IX_TXI]) |=> cnt[IX_TXI] == $past(cnt[IX_TXI]) + CNT_W'(1);
	endproperty
	a_tx_ins: assert property (p_tx_ins) else $error("tx insert not counted");

	property p_rx_drop;
		@(posedge clk) disable iff (!resetn)
		(rate_ev.rx_drop && !clr[IX_RXD]) |=> cnt[IX_RXD] == $past(cnt[IX_RXD]) + CNT_W'(1);
	endproperty
	a_rx_drop: assert property (p_rx_drop) else $error("rx drop not counted");

	property p_rx_drop_keep;
		@(posedge clk) disable iff (!resetn)
		(rate_ev.rx_drop && clr[IX_RXD]) |=> cnt[IX_RXD] == CNT_W'(1);
	endproperty
	a_rx_drop_keep: assert property (p_rx_drop_keep) else $error("event lost during read");

	property p_tx_drop;
		@(posedge clk) disable iff (!resetn)
		(!rate_ev.tx_drop && !clr[IX_TXD]) |=> $stable(cnt[IX_TXD]);
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("tx drop counter moved without event");

	property p_wrong_dev;
		@(posedge clk) disable iff (!resetn)
		(rd_req.rd && rd_req.devad != CNT_DEVAD) |=> (rd_valid && rd_data == RD_UNMAPPED);
	endproperty
	a_wrong_dev: assert property (p_wrong_dev) else $error("other device read not answered with zero");

endmodule // pkt_cnt_bank

// File: mgmt_station.sv
/*
 management station model that issues clear-on-read register reads.
 assumes the caller enters read at a falling clock edge.
*/
module mgmt_station
	import pkt_cnt_pkg::*;
(
	// clock
	input  wire logic clk,
	// read request
	output reg_read_t rd_req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial rd_req = '0;

	// one-cycle pulse, then idle fields show the inverse of the last request
	task automatic read(input logic [DEVAD_W-1:0] devad, input logic [ADDR_W-1:0] addr);
		rd_req = '{rd: 1'b1, devad: devad, addr: addr};
		@(negedge clk);
		rd_req = '{rd: 1'b0, devad: ~devad, addr: ~addr};
		@(negedge clk);
	endtask
endmodule // mgmt_station

// File: pkt_cnt_bank_test.sv
/*
 self-checking bench for the counter bank: reads, column checks and rate events.
 assumes the bank answers each read one cycle later with rd_valid.
*/
module pkt_cnt_bank_test
	import pkt_cnt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [8:0] K9 = {1'b1, CHR_IDLE};
	localparam logic [8:0] A9 = {1'b1, CHR_ALIGN};
	localparam logic [8:0] T9 = {1'b1, CHR_TERM};

	logic               clk;
	logic               resetn;
	column_t            rx_col;
	rate_events_t       rate_ev;
	reg_read_t          rd_req;
	logic               rd_valid;
	logic [CNT_W-1:0]   rd_data;
	logic [CNT_W-1:0]   exp_cnt [NUM_CNT];
	logic [CNT_W-1:0]   exp_q [$];
	int                 num_errors;
	int                 samples_checked;
	int                 cycles;
	int                 seed = 96878;

	pkt_cnt_bank u_dut (.clk(clk), .resetn(resetn), .rx_col(rx_col), .rate_ev(rate_ev),
		.rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data));
	mgmt_station u_sta (.clk(clk), .rd_req(rd_req));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic stop_test;
		if (exp_q.size() != 0) begin
			num_errors++;
			$display("unexpected pending reads: expected 0 seen %0d", exp_q.size());
		end
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_rd(input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected rd_data: expected %h seen %h", exp, seen);
		end
	endtask

	// oldest expected read result against each answer
	always @(negedge clk) begin
		if (resetn === 1'b1 && rd_valid !== 1'b0) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("unexpected rd_valid: expected 0 seen %b", rd_valid);
			end else
				chk_rd(exp_q.pop_front(), rd_data);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			num_errors++;
			$display("unexpected cycle count: expected below 1000 seen %0d", cycles);
			stop_test();
		end
	end

	task automatic rd_cnt(input int i);
		exp_q.push_back(exp_cnt[i]);
		exp_cnt[i] = CNT_CLEARED;
		u_sta.read(CNT_DEVAD, LN2_ERR_ADDR + 16'(i));
	endtask

	task automatic rd_bad(input logic [DEVAD_W-1:0] devad, input logic [ADDR_W-1:0] addr);
		exp_q.push_back(RD_UNMAPPED);
		u_sta.read(devad, addr);
	endtask

	task automatic pulse(input rate_events_t ev);
		rate_ev = ev;
		@(negedge clk);
		rate_ev = '0;
		exp_cnt[IX_TXD] += CNT_W'(ev.tx_drop);
		exp_cnt[IX_TXI] += CNT_W'(ev.tx_insert);
		exp_cnt[IX_RXD] += CNT_W'(ev.rx_drop);
		@(negedge clk);
	endtask

	task automatic col(input logic valid, input logic [COL_W-1:0] c);
		rx_col = '{valid: valid, col: c};
		@(negedge clk);
	endtask

	// terminate column, a skipped cycle for some cases, follower column
	task automatic col_case(input int k);
		logic [8:0]       d [4];
		logic [COL_W-1:0] t;
		logic [COL_W-1:0] f;
		foreach (d[j]) d[j] = {1'b0, 8'($random(seed))};
		case (k)
			0: begin t = {K9, T9, d[1], d[0]}; f = {4{K9}}; end
			1: begin t = {K9, T9, d[1], d[0]}; f = {4{A9}}; end
			2: begin t = {d[3], T9, d[1], d[0]}; f = {4{K9}}; end
			3: begin t = {K9, T9, d[1], d[0]}; f = {K9, K9, d[1], K9}; end
			4: begin t = {d[3], T9, d[1], d[0]}; f = {d[3], d[2], d[1], d[0]}; end
			5: begin t = {T9, d[2], d[1], d[0]}; f = {4{A9}}; end
			default: begin t = {T9, d[2], d[1], d[0]}; f = {K9, K9, K9, d[0]}; end
		endcase
		col(1'b1, t);
		if (k == 1 || k == 3) col(1'b0, ~t);
		col(1'b1, f);
		col(1'b1, {4{K9}});
		col(1'b0, f);
		exp_cnt[IX_LN2] += CNT_W'(k >= 2 && k <= 4);
		exp_cnt[IX_LN3] += CNT_W'(k == 6);
	endtask

	initial begin
		rx_col = '0;
		rate_ev = '0;
		resetn = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		cycles = 0;
		foreach (exp_cnt[i]) exp_cnt[i] = CNT_RESET;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		repeat (4) pulse(rate_events_t'(3'h2));
		rd_bad(5'h02, LN2_ERR_ADDR);
		rd_bad(CNT_DEVAD, 16'h8017);
		rd_bad(CNT_DEVAD, 16'h8011);
		for (int i = 0; i < NUM_CNT; i++) rd_cnt(i);
		for (int i = 0; i < NUM_CNT; i++) rd_cnt(i);
		rd_cnt(IX_LN2);
		$display("test reset_and_clear done");
		for (int k = 0; k < 7; k++) col_case(k);
		rd_cnt(IX_LN2);
		rd_cnt(IX_LN3);
		$display("test packet_end done");
		repeat (20) pulse(rate_events_t'(3'($random(seed))));
		for (int i = IX_TXD; i <= IX_RXD; i++) rd_cnt(i);
		$display("test rate_events done");
		for (int i = IX_TXD; i <= IX_RXD; i++) begin
			fork
				pulse(rate_events_t'(3'h7));
				rd_cnt(i);
			join
		end
		for (int i = IX_TXD; i <= IX_RXD; i++) rd_cnt(i);
		$display("test read_with_event done");
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		foreach (exp_cnt[i]) exp_cnt[i] = CNT_RESET;
		rd_cnt(IX_LN3);
		rd_cnt(IX_RXD);
		$display("test mid_reset done");
		repeat (3) @(negedge clk);
		stop_test();
	end
endmodule // pkt_cnt_bank_test
